// ---- design/mmsr_pkg.sv ----
// Package of constants and types for the module mode strap and reset block
package mmsr_pkg;

   // Operating mode strap codes
   localparam logic [2:0] MODE_PARALLEL  = 3'h0;
   localparam logic [2:0] MODE_SER_19K2  = 3'h1;
   localparam logic [2:0] MODE_SER_57K6  = 3'h2;
   localparam logic [2:0] MODE_SER_115K2 = 3'h3;
   localparam logic [2:0] MODE_SER_625K  = 3'h4;
   localparam logic [2:0] MODE_SERVICE   = 3'h7;

   // Module type codes on module_type_outputs, bit 0 first
   localparam logic [1:0] TYPE_ACTIVE  = 2'h0;
   localparam logic [1:0] TYPE_PASSIVE = 2'h1;

   // Baud select codes
   localparam logic [2:0] BAUD_NONE  = 3'h0;
   localparam logic [2:0] BAUD_19K2  = 3'h1;
   localparam logic [2:0] BAUD_57K6  = 3'h2;
   localparam logic [2:0] BAUD_115K2 = 3'h3;
   localparam logic [2:0] BAUD_625K  = 3'h4;

   // Clock and timing
   localparam int CLK_HZ          = 25000000;
   localparam int RESET_MIN_US    = 100;
   localparam int POWERUP_MIN_MS  = 100;
   localparam int RESET_MIN_CYC   = (CLK_HZ / 1000000) * RESET_MIN_US;
   localparam int POWERUP_MIN_CYC = (CLK_HZ / 1000) * POWERUP_MIN_MS;
   localparam int CNT_W           = 24;
   // Id read window: both synchronisers and the module's data register
   localparam int ID_READ_CYC     = 6;

   // Passive module identification byte on the data lines
   localparam logic [7:0] PASSIVE_ID_DEFAULT = 8'h5A;

   // Host interface register offsets
   localparam logic [3:0] REG_CTRL   = 4'h0;
   localparam logic [3:0] REG_STATUS = 4'h4;
   localparam logic [3:0] REG_STRAP  = 4'h8;
   localparam logic [3:0] REG_ID     = 4'hC;

   // Control register fields
   localparam int CTRL_RESTART = 0;
   localparam int CTRL_READID  = 1;
   localparam int CTRL_SUPPLY  = 2;

   typedef enum logic [3:0] {
      HS_POWERUP = 4'h1,
      HS_RESET   = 4'h2,
      HS_RUN     = 4'h4,
      HS_IDREAD  = 4'h8
   } mmsr_hstate_t;

endpackage : mmsr_pkg

// ---- design/mmsr_link_if.sv ----
// Interface joining host controller and module end
interface mmsr_link_if;
   logic       reset_n;
   logic [2:0] operating_mode_straps;
   logic [1:0] module_type_outputs;
   logic [3:0] network_status_outputs;
   logic       chip_enable_n;
   logic       output_enable_n;
   logic       read_write;
   logic [7:0] data_out;
   logic       data_oe_n;
   logic       safety_link_receive;
   logic       safety_link_transmit;

   modport host (
      output reset_n, operating_mode_straps, chip_enable_n, output_enable_n, read_write,
      output safety_link_receive,
      input  module_type_outputs, network_status_outputs, data_out, data_oe_n,
      input  safety_link_transmit
   );
   modport module_end (
      input  reset_n, operating_mode_straps, chip_enable_n, output_enable_n, read_write,
      input  safety_link_receive,
      output module_type_outputs, network_status_outputs, data_out, data_oe_n,
      output safety_link_transmit
   );
endinterface : mmsr_link_if

// ---- design/mmsr_sync.sv ----
// Two flip-flop synchroniser for a vector of pin inputs
module mmsr_sync #(
   parameter int W = 1
) (
   // Clock and reset
   input  wire logic         clk,
   input  wire logic         rst,
   // Data
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] s1_q;
   logic [W-1:0] s2_q;

   always_ff @(posedge clk) begin
      if (rst) begin
         s1_q <= '0;
         s2_q <= '0;
      end else begin
         s1_q <= d;
         s2_q <= s1_q;
      end
   end
   assign q = s2_q;
endmodule // mmsr_sync

// ---- design/mmsr_module.sv ----
// Module end: strap sampling, interface selection, identification and status
module mmsr_module #(
   parameter bit         IS_PASSIVE = 1'b0,
   parameter logic [7:0] PASSIVE_ID = mmsr_pkg::PASSIVE_ID_DEFAULT
) (
   // Clock and reset
   input  wire logic  clk,
   input  wire logic  rst,
   // Link
   mmsr_link_if.module_end lnk,
   // User side
   input  wire logic [3:0] cpu_status,
   input  wire logic       safety_tx,
   output logic            safety_rx,
   output logic            parallel_enabled,
   output logic            serial_enabled,
   output logic            safety_on_serial,
   output logic            safety_on_channel,
   output logic            service_mode,
   output logic [2:0]      baud_select,
   output logic            in_reset
);
   ////////////////////////////////////////////////////////////////////////////////
   logic [2:0] straps_s;
   logic [4:0] ctl_s;
   logic       rst_n_s;
   logic       ce_n_s;
   logic       oe_n_s;
   logic       rw_s;
   logic       srx_s;

   mmsr_sync #(.W(3)) u_sync_straps (.clk(clk), .rst(rst), .d(lnk.operating_mode_straps),
                                     .q(straps_s));
   mmsr_sync #(.W(5)) u_sync_ctl (.clk(clk), .rst(rst),
      .d({lnk.reset_n, lnk.chip_enable_n, lnk.output_enable_n, lnk.read_write,
          lnk.safety_link_receive}),
      .q(ctl_s));
   assign {rst_n_s, ce_n_s, oe_n_s, rw_s, srx_s} = ctl_s;

   ////////////////////////////////////////////////////////////////////////////////
   // Strap capture at reset release
   logic [2:0] mode_q, mode_d;
   logic       held_q, held_d;
   logic       par_q, par_d, ser_q, ser_d, svc_q, svc_d;
   logic [2:0] baud_q, baud_d;

   always_comb begin
      mode_d = mode_q;
      held_d = ~rst_n_s;
      par_d  = par_q;
      ser_d  = ser_q;
      svc_d  = svc_q;
      baud_d = baud_q;
      if (held_q && rst_n_s) begin
         mode_d = straps_s;
         par_d  = 1'b0;
         ser_d  = 1'b0;
         svc_d  = 1'b0;
         baud_d = mmsr_pkg::BAUD_NONE;
         if (IS_PASSIVE) begin
            ser_d = 1'b1;
         end else begin
            case (straps_s)
               mmsr_pkg::MODE_PARALLEL:  par_d = 1'b1;
               mmsr_pkg::MODE_SER_19K2: begin
                  ser_d  = 1'b1;
                  baud_d = mmsr_pkg::BAUD_19K2;
               end
               mmsr_pkg::MODE_SER_57K6: begin
                  ser_d  = 1'b1;
                  baud_d = mmsr_pkg::BAUD_57K6;
               end
               mmsr_pkg::MODE_SER_115K2: begin
                  ser_d  = 1'b1;
                  baud_d = mmsr_pkg::BAUD_115K2;
               end
               mmsr_pkg::MODE_SER_625K: begin
                  ser_d  = 1'b1;
                  baud_d = mmsr_pkg::BAUD_625K;
               end
               mmsr_pkg::MODE_SERVICE: svc_d = 1'b1;
               default: ;
            endcase
         end
      end else if (!rst_n_s) begin
         par_d  = 1'b0;
         ser_d  = 1'b0;
         svc_d  = 1'b0;
         baud_d = mmsr_pkg::BAUD_NONE;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         mode_q <= mmsr_pkg::MODE_PARALLEL;
         held_q <= 1'b1;
         par_q  <= 1'b0;
         ser_q  <= 1'b0;
         svc_q  <= 1'b0;
         baud_q <= mmsr_pkg::BAUD_NONE;
      end else begin
         mode_q <= mode_d;
         held_q <= held_d;
         par_q  <= par_d;
         ser_q  <= ser_d;
         svc_q  <= svc_d;
         baud_q <= baud_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Outputs toward the host, and the registered safety link receive toward the user side
   logic [3:0] stat_q;
   logic [7:0] dout_q;
   logic       doe_n_q;
   logic       stx_q;
   logic       srx_q;
   logic       id_rd;

   assign id_rd = IS_PASSIVE && !ce_n_s && !oe_n_s && rw_s;

   always_ff @(posedge clk) begin
      if (rst) begin
         stat_q  <= 4'h0;
         dout_q  <= 8'h00;
         doe_n_q <= 1'b1;
         stx_q   <= 1'b1;
         srx_q   <= 1'b1;
      end else begin
         stat_q  <= held_q ? 4'h0 : cpu_status;
         dout_q  <= id_rd ? PASSIVE_ID : 8'h00;
         doe_n_q <= ~id_rd;
         stx_q   <= safety_tx;
         srx_q   <= srx_s;
      end
   end

   assign lnk.module_type_outputs    = IS_PASSIVE ? mmsr_pkg::TYPE_PASSIVE
                                                  : mmsr_pkg::TYPE_ACTIVE;
   assign lnk.network_status_outputs = stat_q;
   assign lnk.data_out               = dout_q;
   assign lnk.data_oe_n              = doe_n_q;
   assign lnk.safety_link_transmit   = stx_q;
   assign safety_rx                  = srx_q;

   assign parallel_enabled  = par_q;
   assign serial_enabled    = ser_q;
   assign service_mode      = svc_q;
   assign baud_select       = baud_q;
   assign in_reset          = held_q;
   assign safety_on_serial  = par_q;
   assign safety_on_channel = ser_q && !IS_PASSIVE;
endmodule // mmsr_module

// ---- design/mmsr_host.sv ----
// Host end: reset sequencing, strap drive and identification readout
module mmsr_host #(
   parameter int POWERUP_CYC = mmsr_pkg::POWERUP_MIN_CYC
) (
   // Clock and reset
   input  wire logic  clk,
   input  wire logic  rst,
   // Link
   mmsr_link_if.host  lnk,
   // Software port
   input  wire logic [3:0] addr,
   input  wire logic [7:0] wdata,
   input  wire logic       wr,
   input  wire logic       rd,
   output logic      [7:0] rdata
);
   ////////////////////////////////////////////////////////////////////////////////
   logic [1:0] type_s;
   logic [3:0] stat_s;
   logic [8:0] dat_s;
   logic       stx_s;

   mmsr_sync #(.W(16)) u_sync_in (.clk(clk), .rst(rst),
      .d({lnk.module_type_outputs, lnk.network_status_outputs, lnk.data_oe_n, lnk.data_out,
          lnk.safety_link_transmit}),
      .q({type_s, stat_s, dat_s, stx_s}));

   ////////////////////////////////////////////////////////////////////////////////
   // Registers and sequencer
   mmsr_pkg::mmsr_hstate_t st_q, st_d;
   logic [mmsr_pkg::CNT_W-1:0] cnt_q, cnt_d;
   logic [2:0] strap_q, strap_d;
   logic       supply_ok_q, supply_ok_d;
   logic       restart_q, restart_d;
   logic       idreq_q, idreq_d;
   logic       typed_q, typed_d;
   logic [7:0] id_q, id_d;
   logic [7:0] rdata_q, rdata_d;

   localparam logic [mmsr_pkg::CNT_W-1:0] PU_CNT  = mmsr_pkg::CNT_W'(POWERUP_CYC);
   localparam logic [mmsr_pkg::CNT_W-1:0] RST_CNT = mmsr_pkg::CNT_W'(mmsr_pkg::RESET_MIN_CYC);
   localparam logic [mmsr_pkg::CNT_W-1:0] ID_CNT  = mmsr_pkg::CNT_W'(mmsr_pkg::ID_READ_CYC);

   always_comb begin
      st_d        = st_q;
      cnt_d       = cnt_q;
      strap_d     = strap_q;
      supply_ok_d = supply_ok_q;
      restart_d   = restart_q;
      idreq_d     = idreq_q;
      typed_d     = typed_q;
      id_d        = id_q;
      rdata_d     = 8'h00;
      if (rd) begin
         case (addr)
            mmsr_pkg::REG_CTRL:   rdata_d = {5'h00, supply_ok_q, idreq_q, restart_q};
            mmsr_pkg::REG_STATUS: rdata_d = {typed_q, (st_q == mmsr_pkg::HS_RUN), type_s,
                                             stat_s};
            mmsr_pkg::REG_STRAP:  rdata_d = {5'h00, strap_q};
            mmsr_pkg::REG_ID:     rdata_d = id_q;
            default:              rdata_d = 8'h00;
         endcase
      end
      if (cnt_q != '0) begin
         cnt_d = cnt_q - 1'b1;
      end
      case (st_q)
         mmsr_pkg::HS_POWERUP: begin
            if (!supply_ok_q) begin
               cnt_d = PU_CNT;
            end else if (cnt_q == '0) begin
               st_d = mmsr_pkg::HS_RUN;
            end
         end
         mmsr_pkg::HS_RESET: begin
            if (!supply_ok_q) begin
               st_d  = mmsr_pkg::HS_POWERUP;
               cnt_d = PU_CNT;
            end else if (cnt_q == '0) begin
               st_d = mmsr_pkg::HS_RUN;
            end
         end
         mmsr_pkg::HS_RUN: begin
            typed_d = 1'b1;
            if (!supply_ok_q) begin
               st_d    = mmsr_pkg::HS_POWERUP;
               cnt_d   = PU_CNT;
               typed_d = 1'b0;
            end else if (restart_q) begin
               st_d      = mmsr_pkg::HS_RESET;
               cnt_d     = RST_CNT;
               restart_d = 1'b0;
               typed_d   = 1'b0;
            end else if (idreq_q && typed_q && type_s == mmsr_pkg::TYPE_PASSIVE) begin
               st_d    = mmsr_pkg::HS_IDREAD;
               cnt_d   = ID_CNT;
               idreq_d = 1'b0;
            end else begin
               idreq_d = 1'b0;
            end
         end
         mmsr_pkg::HS_IDREAD: begin
            if (cnt_q == '0) begin
               if (!dat_s[8]) begin
                  id_d = dat_s[7:0];
               end
               st_d = mmsr_pkg::HS_RUN;
            end
         end
         default: st_d = mmsr_pkg::HS_POWERUP;
      endcase
      // Writes come after the sequencer so a new request beats its clear
      if (wr) begin
         case (addr)
            mmsr_pkg::REG_CTRL: begin
               restart_d   = restart_d | wdata[mmsr_pkg::CTRL_RESTART];
               idreq_d     = idreq_d | wdata[mmsr_pkg::CTRL_READID];
               supply_ok_d = wdata[mmsr_pkg::CTRL_SUPPLY];
            end
            // Reserved and service codes fall back to parallel
            mmsr_pkg::REG_STRAP: strap_d = (wdata[2:0] > mmsr_pkg::MODE_SER_625K)
                                           ? mmsr_pkg::MODE_PARALLEL : wdata[2:0];
            default: ;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         st_q        <= mmsr_pkg::HS_POWERUP;
         cnt_q       <= '0;
         strap_q     <= mmsr_pkg::MODE_PARALLEL;
         supply_ok_q <= 1'b0;
         restart_q   <= 1'b0;
         idreq_q     <= 1'b0;
         typed_q     <= 1'b0;
         id_q        <= 8'h00;
         rdata_q     <= 8'h00;
      end else begin
         st_q        <= st_d;
         cnt_q       <= cnt_d;
         strap_q     <= strap_d;
         supply_ok_q <= supply_ok_d;
         restart_q   <= restart_d;
         idreq_q     <= idreq_d;
         typed_q     <= typed_d;
         id_q        <= id_d;
         rdata_q     <= rdata_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Pin drive; straps are only changeable via register while reset is held
   logic [2:0] pins_strap_q;
   logic       rst_n_q;
   logic       idpins_q;

   always_ff @(posedge clk) begin
      if (rst) begin
         pins_strap_q <= mmsr_pkg::MODE_PARALLEL;
         rst_n_q      <= 1'b0;
         idpins_q     <= 1'b0;
      end else begin
         if (st_q != mmsr_pkg::HS_RUN && st_q != mmsr_pkg::HS_IDREAD) begin
            pins_strap_q <= strap_q;
         end
         rst_n_q  <= (st_d == mmsr_pkg::HS_RUN) || (st_d == mmsr_pkg::HS_IDREAD);
         idpins_q <= (st_d == mmsr_pkg::HS_IDREAD);
      end
   end

   assign lnk.reset_n               = rst_n_q;
   assign lnk.operating_mode_straps = pins_strap_q;
   assign lnk.chip_enable_n         = ~idpins_q;
   assign lnk.output_enable_n       = ~idpins_q;
   assign lnk.read_write            = 1'b1;
   assign lnk.safety_link_receive   = stx_s;
   assign rdata                     = rdata_q;
endmodule // mmsr_host

// ---- verification/mmsr_sva.sv ----
// Checker for the link between the host end and the active module end
module mmsr_sva #(
   parameter int POWERUP_CYC = 50
) (
   // Clock and reset
   input wire logic       clk,
   input wire logic       rst,
   // Link
   input wire logic       reset_n,
   input wire logic [2:0] operating_mode_straps,
   input wire logic [1:0] module_type_outputs,
   input wire logic [3:0] network_status_outputs,
   input wire logic       chip_enable_n,
   input wire logic       output_enable_n,
   input wire logic       read_write,
   input wire logic       data_oe_n,
   // Module user side
   input wire logic [3:0] cpu_status,
   input wire logic       parallel_enabled,
   input wire logic       serial_enabled,
   input wire logic [2:0] baud_select,
   input wire logic       in_reset
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [15:0] low_cnt_q, low_cnt_d;
   logic        up_seen_q, up_seen_d;
   logic [3:0]  run_cnt_q, run_cnt_d;

   ////////////////////////////////////////////////////////////////////////////
   // Length of each low phase of the module reset, and time since release
   always_comb begin
      low_cnt_d = reset_n ? 16'h0 : low_cnt_q + {15'h0, low_cnt_q != 16'hFFFF};
      up_seen_d = up_seen_q | reset_n;
      run_cnt_d = in_reset ? 4'h0 : run_cnt_q + {3'h0, run_cnt_q != 4'h8};
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         low_cnt_q <= 16'h0;
         up_seen_q <= 1'b0;
         run_cnt_q <= 4'h0;
      end else begin
         low_cnt_q <= low_cnt_d;
         up_seen_q <= up_seen_d;
         run_cnt_q <= run_cnt_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   property p_reset_low_after_rst;
      $fell(rst) |-> !reset_n;
   endproperty
   a_reset_low_after_rst: assert property (p_reset_low_after_rst)
      else $error("module reset not low after host reset");

   property p_powerup_hold;
      !up_seen_q && reset_n && low_cnt_q != 16'h0 |-> int'(low_cnt_q) >= POWERUP_CYC;
   endproperty
   a_powerup_hold: assert property (p_powerup_hold)
      else $error("power-up reset released too early");

   property p_restart_width;
      up_seen_q && reset_n && low_cnt_q != 16'h0
         |-> int'(low_cnt_q) >= mmsr_pkg::RESET_MIN_CYC;
   endproperty
   a_restart_width: assert property (p_restart_width)
      else $error("restart pulse too short");

   property p_straps_stable;
      reset_n && $past(reset_n) |-> $stable(operating_mode_straps);
   endproperty
   a_straps_stable: assert property (p_straps_stable)
      else $error("straps moved while reset released");

   property p_enter_reset;
      $fell(reset_n) |-> ##[1:6] in_reset;
   endproperty
   a_enter_reset: assert property (p_enter_reset)
      else $error("module did not enter reset");

   property p_sample_once;
      !in_reset && run_cnt_q == 4'h8
         |-> $stable(baud_select) && $stable(parallel_enabled) && $stable(serial_enabled);
   endproperty
   a_sample_once: assert property (p_sample_once)
      else $error("interface selection changed while running");

   property p_parallel;
      $rose(parallel_enabled) |-> operating_mode_straps == mmsr_pkg::MODE_PARALLEL
         && !serial_enabled;
   endproperty
   a_parallel: assert property (p_parallel)
      else $error("parallel enabled for a serial code");

   property p_baud;
      $rose(serial_enabled) |-> baud_select == operating_mode_straps && !parallel_enabled;
   endproperty
   a_baud: assert property (p_baud)
      else $error("baud select does not follow straps");

   property p_type_active;
      module_type_outputs == mmsr_pkg::TYPE_ACTIVE;
   endproperty
   a_type_active: assert property (p_type_active)
      else $error("active module reports wrong type");

   property p_status_mirror;
      (!in_reset && $stable(cpu_status)) [*4] |-> network_status_outputs == cpu_status;
   endproperty
   a_status_mirror: assert property (p_status_mirror)
      else $error("status outputs do not mirror cpu status");

   property p_id_select;
      !chip_enable_n |-> !output_enable_n && read_write && data_oe_n;
   endproperty
   a_id_select: assert property (p_id_select)
      else $error("bad id read select or active module drives data");
endmodule // mmsr_sva

// ---- verification/mmsr_tb_top.sv ----
// Testbench top: host ends joined to an active and a passive module end
module mmsr_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int         PWR_CYC = 50;
   localparam logic [7:0] ID_BYTE = 8'hC3;
   logic       clk, rst, wr, rd, safety_tx;
   logic [3:0] addr, cpu_status;
   logic [7:0] wdata, rdata_a, rdata_p;
   logic [1:0] par, ser, son, sch, svc, srx, inr;
   logic [2:0] baud_a, baud_p;
   int         fail_count, checked;
   int         cycles = 0;

   mmsr_link_if lnk_a ();
   mmsr_link_if lnk_p ();

   mmsr_host #(.POWERUP_CYC(PWR_CYC)) u_mmsr_host (.clk(clk), .rst(rst), .lnk(lnk_a),
      .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata_a));
   mmsr_host #(.POWERUP_CYC(PWR_CYC)) u_mmsr_host_p (.clk(clk), .rst(rst), .lnk(lnk_p),
      .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata_p));
   mmsr_module u_mmsr_module (.clk(clk), .rst(rst), .lnk(lnk_a), .cpu_status(cpu_status),
      .safety_tx(safety_tx), .safety_rx(srx[0]), .parallel_enabled(par[0]),
      .serial_enabled(ser[0]), .safety_on_serial(son[0]), .safety_on_channel(sch[0]),
      .service_mode(svc[0]), .baud_select(baud_a), .in_reset(inr[0]));
   mmsr_module #(.IS_PASSIVE(1'b1), .PASSIVE_ID(ID_BYTE)) u_mmsr_module_p (.clk(clk),
      .rst(rst), .lnk(lnk_p), .cpu_status(cpu_status), .safety_tx(safety_tx),
      .safety_rx(srx[1]), .parallel_enabled(par[1]), .serial_enabled(ser[1]),
      .safety_on_serial(son[1]), .safety_on_channel(sch[1]), .service_mode(svc[1]),
      .baud_select(baud_p), .in_reset(inr[1]));
   mmsr_sva #(.POWERUP_CYC(PWR_CYC)) u_mmsr_sva (.clk(clk), .rst(rst),
      .reset_n(lnk_a.reset_n), .operating_mode_straps(lnk_a.operating_mode_straps),
      .module_type_outputs(lnk_a.module_type_outputs),
      .network_status_outputs(lnk_a.network_status_outputs),
      .chip_enable_n(lnk_a.chip_enable_n), .output_enable_n(lnk_a.output_enable_n),
      .read_write(lnk_a.read_write), .data_oe_n(lnk_a.data_oe_n), .cpu_status(cpu_status),
      .parallel_enabled(par[0]), .serial_enabled(ser[0]), .baud_select(baud_a),
      .in_reset(inr[0]));

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   always @(posedge clk) begin
      cycles++;
      if (cycles == 40000) begin
         fail_count++;
         $display("[FAIL] %0t run did not finish in time", $time);
         summarize();
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   task automatic summarize();
      $display("Mismatches %0d, checks %0d", fail_count, checked);
      if (fail_count == 0 && checked > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checked++;
      if (got !== exp) begin
         fail_count++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic settle(input int n);
      repeat (n) @(posedge clk);
      @(negedge clk);
   endtask

   task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask

   task automatic rd_reg(input logic [3:0] a, output logic [7:0] da, output logic [7:0] dp);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      @(negedge clk);
      da = rdata_a;
      dp = rdata_p;
   endtask

   // Bounded wait for the module reset line to reach a level
   task automatic wait_link(input logic lvl);
      int n;
      n = 0;
      while (lnk_a.reset_n !== lvl && n < 4000) begin
         @(posedge clk);
         n++;
      end
      settle(8);
      chk({7'h0, lnk_a.reset_n}, {7'h0, lvl});
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // Every strap code, each applied through a restart except code 0, which is applied at power-up
   task automatic t_modes();
      logic [2:0] code, eff, prev;
      logic [7:0] ra, rp;
      prev = 3'h0;
      for (int i = 0; i < 8; i++) begin
         code = 3'(i);
         eff = (code > 3'h4) ? 3'h0 : code;
         wr_reg(mmsr_pkg::REG_STRAP, {5'h0, code});
         settle(20);
         chk({5'h0, baud_a}, {5'h0, prev});
         wr_reg(mmsr_pkg::REG_CTRL, (i == 0) ? 8'h04 : 8'h05);
         if (i != 0) begin
            wait_link(1'b0);
            chk({6'h0, inr}, 8'h03);
         end
         wait_link(1'b1);
         rd_reg(mmsr_pkg::REG_STRAP, ra, rp);
         chk(ra, {5'h0, eff});
         chk({7'h0, par[0]}, {7'h0, eff == 3'h0});
         chk({7'h0, ser[0]}, {7'h0, eff != 3'h0});
         chk({5'h0, baud_a}, {5'h0, eff});
         chk({6'h0, son[0], sch[0]}, (eff == 3'h0) ? 8'h02 : 8'h01);
         chk({6'h0, par[1], ser[1]}, 8'h01);
         chk({5'h0, baud_p}, 8'h00);
         chk({6'h0, svc}, 8'h00);
         prev = eff;
      end
   endtask

   task automatic t_status();
      logic [7:0] ra, rp;
      chk({6'h0, lnk_a.module_type_outputs}, {6'h0, mmsr_pkg::TYPE_ACTIVE});
      chk({6'h0, lnk_p.module_type_outputs}, {6'h0, mmsr_pkg::TYPE_PASSIVE});
      @(posedge clk);
      cpu_status <= 4'hA;
      safety_tx <= 1'b1;
      settle(8);
      chk({4'h0, lnk_a.network_status_outputs}, 8'h0A);
      chk({6'h0, srx}, 8'h03);
      rd_reg(mmsr_pkg::REG_STATUS, ra, rp);
      chk({4'h0, ra[3:0]}, 8'h0A);
      chk({6'h0, rp[5:4]}, {6'h0, mmsr_pkg::TYPE_PASSIVE});
      @(posedge clk);
      cpu_status <= 4'h5;
      safety_tx <= 1'b0;
      settle(8);
      chk({4'h0, lnk_p.network_status_outputs}, 8'h05);
      chk({6'h0, srx}, 8'h00);
   endtask

   task automatic t_idread();
      logic [7:0] ra, rp;
      wr_reg(mmsr_pkg::REG_CTRL, 8'h06);
      settle(20);
      rd_reg(mmsr_pkg::REG_ID, ra, rp);
      chk(rp, ID_BYTE);
      chk(ra, 8'h00);
      chk({6'h0, lnk_p.data_oe_n, lnk_p.chip_enable_n}, 8'h03);
   endtask

   task automatic t_supply();
      wr_reg(mmsr_pkg::REG_CTRL, 8'h00);
      settle(3);
      chk({6'h0, lnk_a.reset_n, lnk_p.reset_n}, 8'h00);
   endtask

   initial begin
      rst = 1'b1;
      wr = 1'b0;
      rd = 1'b0;
      addr = 4'h0;
      wdata = 8'h00;
      cpu_status = 4'h0;
      safety_tx = 1'b0;
      fail_count = 0;
      checked = 0;
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      t_modes();
      t_status();
      t_idread();
      t_supply();
      summarize();
   end
endmodule // mmsr_tb_top
